// ### pkg/etc_holdoff_if.sv
// Purpose: link between the trigger control and its holdoff timer
// Assumes: one clock domain
// Notes:   start is a one-cycle pulse, fire a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface etc_holdoff_if;
    import etc_pkg::*;
    logic       start;
    etc_delay_t delay_ms;
    logic       busy;
    logic       fire;
    modport ctrl  (output start, output delay_ms, input busy, input fire);
    modport timer (input start, input delay_ms, output busy, output fire);
endinterface : etc_holdoff_if
`default_nettype wire

// ### pkg/etc_pkg.sv
// Purpose: constants and types for the external trigger start control
// Assumes: 20 MHz system clock
// Notes:   settings reach the block as plain ports with write strobes
package etc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned DELAY_MAX_MS  = 1000;
    localparam int unsigned DELAY_W       = 10;
    localparam int unsigned NUM_CH        = 2;

    typedef logic [1:0]         etc_enable_t;
    typedef logic [1:0]         etc_start_t;
    typedef logic [2:0]         etc_stop_t;
    typedef logic [DELAY_W-1:0] etc_delay_t;

    localparam etc_enable_t ENABLE_OFF  = 2'h0;
    localparam etc_enable_t ENABLE_A    = 2'h1;
    localparam etc_enable_t ENABLE_B    = 2'h2;
    localparam etc_enable_t ENABLE_BOTH = 2'h3;

    localparam logic POL_FALLING = 1'b0;
    localparam logic POL_RISING  = 1'b1;

    localparam etc_start_t START_CONT = 2'h0;
    localparam etc_start_t START_EXT  = 2'h1;
    localparam etc_start_t START_KEY  = 2'h2;
    localparam etc_start_t START_ARM  = 2'h3;

    localparam etc_stop_t STOP_NEVER = 3'h0;
    localparam etc_stop_t STOP_EXT   = 3'h1;
    localparam etc_stop_t STOP_KEY   = 3'h2;
    localparam etc_stop_t STOP_ARM   = 3'h3;
    localparam etc_stop_t STOP_MAX   = 3'h6;

    localparam logic ARM_WAITING   = 1'b0;
    localparam logic ARM_TRIGGERED = 1'b1;

    localparam etc_enable_t RST_ENABLE = ENABLE_OFF;
    localparam logic        RST_POL    = POL_RISING;
    localparam etc_delay_t  RST_DELAY  = 10'h000;
    localparam etc_start_t  RST_START  = START_CONT;
    localparam etc_stop_t   RST_STOP   = STOP_NEVER;

    typedef enum logic [1:0] {
        ST_ARMED = 2'b00,
        ST_HOLD  = 2'b01,
        ST_RUN   = 2'b11,
        ST_DONE  = 2'b10
    } etc_state_e;
endpackage : etc_pkg

// ### src/etc_holdoff.sv
// Purpose: millisecond holdoff between a trigger edge and its effect
// Assumes: start only honoured while idle
// Notes:   delay sampled at start, so later writes do not move a running holdoff
`timescale 1ns/1ps
`default_nettype none
module etc_holdoff #(
    parameter int unsigned CYC_PER_MS = etc_pkg::CYC_PER_MS
) (
    input  wire logic   clk,
    input  wire logic   rst,
    etc_holdoff_if.timer hif
);
    import etc_pkg::*;

    initial begin
        if (CYC_PER_MS < 1 || CYC_PER_MS > 32'h00ffffff)
            $error("etc_holdoff: CYC_PER_MS out of range");
    end

    logic [23:0] cyc;
    etc_delay_t  ms;
    etc_delay_t  target;
    logic        busy;
    logic        fire;

    assign hif.busy = busy;
    assign hif.fire = fire;

    // divider restarts at the edge so every holdoff is exact to a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy   <= 1'b0;
            fire   <= 1'b0;
            cyc    <= 24'h000000;
            ms     <= '0;
            target <= '0;
        end else begin
            fire <= 1'b0;
            if (hif.start && !busy) begin
                busy   <= 1'b1;
                cyc    <= 24'h000000;
                ms     <= '0;
                target <= hif.delay_ms;
            end else if (busy) begin
                if (ms == target) begin
                    busy <= 1'b0;
                    fire <= 1'b1;
                end else if (cyc == 24'(CYC_PER_MS - 1)) begin
                    cyc <= 24'h000000;
                    ms  <= ms + 10'h001;
                end else begin
                    cyc <= cyc + 24'h000001;
                end
            end
        end
    end
endmodule : etc_holdoff
`default_nettype wire

// ### src/etc_trigger_top.sv
// Purpose: external trigger enable, edge, holdoff and start/stop control
// Assumes: setting ports and SOFT_KEY come from logic on REF_CLK
// Notes:   out-of-range writes are ignored, the old setting stays
// Contract
// - enable code: 0 off, 1 channel A, 2 channel B, 3 both
// - enable code gates the external trigger's effect per channel; only the external start is gated per channel, an external stop ends both
// - enable read returns 0 off, or 1, 2, 3 for A, B, both
// - polarity 0 selects falling edge, 1 selects rising edge
// - polarity read returns the active edge in written encoding
// - holdoff 0 to 1000 ms delays a trigger taking effect; only the external start is delayed, an external stop acts at once
// - holdoff read returns the stored delay in milliseconds
// - start select 0 to 3; 0 means continuous measurement
// - start select 1 starts on enabled external trigger after holdoff
// - start 2 starts on soft key, 3 on arm command value 1
// - arm state 0 armed and waiting, 1 triggered, measuring or stopped
// - stop select 1 ends measurement on an external trigger
`timescale 1ns/1ps
`default_nettype none
module etc_trigger_top #(
    parameter int unsigned CYC_PER_MS = etc_pkg::CYC_PER_MS
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 EXT_TRIG_PIN,
    input  wire logic                 ENABLE_WR,
    input  wire etc_pkg::etc_enable_t ENABLE_IN,
    input  wire logic                 POLARITY_WR,
    input  wire logic                 POLARITY_IN,
    input  wire logic                 DELAY_WR,
    input  wire etc_pkg::etc_delay_t  DELAY_IN,
    input  wire logic                 START_WR,
    input  wire etc_pkg::etc_start_t  START_IN,
    input  wire logic                 STOP_WR,
    input  wire etc_pkg::etc_stop_t   STOP_IN,
    input  wire logic                 ARM_WR,
    input  wire logic                 ARM_IN,
    input  wire logic                 SOFT_KEY,
    output logic                      EXT_TRIGGER_CHANNEL_ENABLE,
    output etc_pkg::etc_enable_t      EXT_ENABLE,
    output logic                      TRIGGER_POLARITY_SELECT,
    output etc_pkg::etc_delay_t       TRIGGER_DELAY_MS,
    output etc_pkg::etc_start_t       START_EVENT_SELECT,
    output etc_pkg::etc_stop_t        STOP_EVENT_SELECT,
    output logic                      ARM_STATE,
    output logic [1:0]                MEAS_RUN,
    output logic                      TRIG_EVENT
);
    import etc_pkg::*;

    initial begin
        if (CYC_PER_MS < 1) $error("etc_trigger_top: CYC_PER_MS must be positive");
    end

    etc_holdoff_if hif ();
    etc_holdoff #(.CYC_PER_MS(CYC_PER_MS)) u_holdoff (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .hif (hif)
    );

    // settings
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            EXT_ENABLE              <= RST_ENABLE;
            TRIGGER_POLARITY_SELECT <= RST_POL;
            TRIGGER_DELAY_MS        <= RST_DELAY;
            START_EVENT_SELECT      <= RST_START;
            STOP_EVENT_SELECT       <= RST_STOP;
        end else begin
            if (ENABLE_WR) EXT_ENABLE <= ENABLE_IN;
            if (POLARITY_WR) TRIGGER_POLARITY_SELECT <= POLARITY_IN;
            if (DELAY_WR && DELAY_IN <= DELAY_W'(DELAY_MAX_MS))
                TRIGGER_DELAY_MS <= DELAY_IN;
            if (START_WR) START_EVENT_SELECT <= START_IN;
            if (STOP_WR && STOP_IN <= STOP_MAX) STOP_EVENT_SELECT <= STOP_IN;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) EXT_TRIGGER_CHANNEL_ENABLE <= 1'b0;
        else EXT_TRIGGER_CHANNEL_ENABLE <= (EXT_ENABLE != ENABLE_OFF);
    end

    // pin synchroniser; level only moves once stages two and three agree
    logic [2:0] sync;
    logic       pin_level;
    logic       pin_prev;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sync      <= 3'h0;
            pin_level <= 1'b0;
            pin_prev  <= 1'b0;
        end else begin
            sync <= {sync[1:0], EXT_TRIG_PIN};
            if (sync[1] == sync[2]) pin_level <= sync[2];
            pin_prev <= pin_level;
        end
    end

    logic edge_seen;
    logic ext_event;
    assign edge_seen = (TRIGGER_POLARITY_SELECT == POL_RISING)
                     ? (pin_level && !pin_prev)
                     : (!pin_level && pin_prev);
    assign ext_event = edge_seen && (EXT_ENABLE != ENABLE_OFF);

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) TRIG_EVENT <= 1'b0;
        else TRIG_EVENT <= ext_event;
    end

    // start/stop sequencing
    etc_state_e state;
    etc_state_e next_state;
    logic       stop_hit;
    assign stop_hit = (STOP_EVENT_SELECT == STOP_EXT && ext_event)
                   || (STOP_EVENT_SELECT == STOP_KEY && SOFT_KEY)
                   || (STOP_EVENT_SELECT == STOP_ARM && ARM_WR && !ARM_IN);

    assign hif.start    = (state == ST_ARMED) && (START_EVENT_SELECT == START_EXT)
                        && ext_event;
    assign hif.delay_ms = TRIGGER_DELAY_MS;

    always_comb begin
        next_state = state;
        case (state)
            ST_ARMED: begin
                case (START_EVENT_SELECT)
                    START_CONT: next_state = ST_RUN;
                    START_EXT:  if (ext_event) next_state = ST_HOLD;
                    START_KEY:  if (SOFT_KEY) next_state = ST_RUN;
                    START_ARM:  if (ARM_WR && ARM_IN) next_state = ST_RUN;
                    default:    next_state = ST_ARMED;
                endcase
            end
            ST_HOLD: begin
                if (hif.fire) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (stop_hit) next_state = ST_DONE;
            end
            ST_DONE: begin
                if (ARM_WR && !ARM_IN) next_state = ST_ARMED;
            end
            default: next_state = ST_ARMED;
        endcase
        // re-arm from run also allowed unless stop select is 3; leaves measurement and waits again
        if (state != ST_DONE && ARM_WR && !ARM_IN && STOP_EVENT_SELECT != STOP_ARM)
            next_state = ST_ARMED;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) state <= ST_ARMED;
        else state <= next_state;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) ARM_STATE <= ARM_WAITING;
        else ARM_STATE <= (next_state == ST_RUN || next_state == ST_DONE)
                        ? ARM_TRIGGERED : ARM_WAITING;
    end

    // on an external start only enabled channels measure
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            always_ff @(posedge REF_CLK) begin
                if (SYS_RST) MEAS_RUN[ch] <= 1'b0;
                else MEAS_RUN[ch] <= (next_state == ST_RUN)
                    && (START_EVENT_SELECT != START_EXT || EXT_ENABLE[ch]);
            end
        end
    endgenerate

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_ext_start;
        state == ST_ARMED && START_EVENT_SELECT == START_EXT && ext_event;
    endsequence

    hold_entry_a: assert property (s_ext_start |=> state == ST_HOLD)
        else $error("external start did not enter holdoff");
    // timer fires two cycles after the edge, state follows one cycle later
    zero_holdoff_a: assert property (
        (s_ext_start and TRIGGER_DELAY_MS == 10'h000) |=> ##2 state == ST_RUN)
        else $error("zero holdoff did not start within three cycles");
    hold_wait_a: assert property (
        (s_ext_start and TRIGGER_DELAY_MS != 10'h000) |=> state == ST_HOLD [*2])
        else $error("holdoff left too early");
    gate_off_a: assert property (
        EXT_ENABLE == ENABLE_OFF && state == ST_ARMED && START_EVENT_SELECT == START_EXT
        |=> state == ST_ARMED && !TRIG_EVENT)
        else $error("disabled trigger had effect");
    holdoff_busy_a: assert property (
        state == ST_HOLD |-> hif.busy || hif.fire)
        else $error("holdoff state without a running timer");
    edge_rise_a: assert property (
        ext_event && TRIGGER_POLARITY_SELECT == POL_RISING
        |-> pin_level && $past(pin_level) == 1'b0)
        else $error("rising edge mismatch");
    edge_fall_a: assert property (
        ext_event && TRIGGER_POLARITY_SELECT == POL_FALLING
        |-> !pin_level && $past(pin_level) == 1'b1)
        else $error("falling edge mismatch");
    delay_range_a: assert property (TRIGGER_DELAY_MS <= DELAY_W'(DELAY_MAX_MS))
        else $error("holdoff above limit");
    ext_stop_a: assert property (
        state == ST_RUN && STOP_EVENT_SELECT == STOP_EXT && ext_event
        |=> state == ST_DONE ##1 ARM_STATE == ARM_TRIGGERED)
        else $error("external stop not taken");
    arm_start_a: assert property (
        state == ST_ARMED && START_EVENT_SELECT == START_ARM && ARM_WR && ARM_IN
        |=> ARM_STATE == ARM_TRIGGERED && state == ST_RUN)
        else $error("arm command did not start");
    cont_run_a: assert property (
        state == ST_ARMED && START_EVENT_SELECT == START_CONT && !ARM_WR
        |=> MEAS_RUN == 2'h3)
        else $error("continuous mode not running");
endmodule : etc_trigger_top
`default_nettype wire

// ### verif/etc_trig_source.sv
// Purpose: external instrument driving the back-panel trigger pin
// Assumes: push-pull pin, so it always shows a driven level
// Notes:   HOLD sets how slowly the instrument changes level
`timescale 1ns/1ps
`default_nettype none
module etc_trig_source #(
    parameter int unsigned HOLD = 4
) (
    input  wire logic clk,
    output var  logic pin
);
    initial pin = 1'b0;

    // levels shorter than two cycles may be lost in the synchroniser
    task automatic drive(input logic lvl);
        repeat (HOLD) @(posedge clk);
        pin <= lvl;
    endtask : drive
endmodule : etc_trig_source
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench for the external trigger start control
// Assumes: CYC_PER_MS cut to 10 so a holdoff of 2 ms is 20 cycles
// Notes:   settings go in through the strobe ports, pin from the source model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import etc_pkg::*;
    localparam int unsigned CPM = 10;
    logic        ref_clk  = 1'b0;
    logic        sys_rst  = 1'b1;
    wire logic   ext_pin;
    logic        en_wr    = 1'b0;
    logic        pol_wr   = 1'b0;
    logic        dly_wr   = 1'b0;
    logic        st_wr    = 1'b0;
    logic        sp_wr    = 1'b0;
    logic        arm_wr   = 1'b0;
    logic        pol_in   = 1'b0;
    logic        arm_in   = 1'b0;
    logic        soft_key = 1'b0;
    logic [9:0]  dly_in   = 10'h000;
    logic [1:0]  en_in    = 2'h0;
    logic [1:0]  st_in    = 2'h0;
    logic [2:0]  sp_in    = 3'h0;
    logic        chan_en, pol_rb, arm_st, trig_ev;
    etc_enable_t ext_en;
    etc_delay_t  dly_rb;
    etc_start_t  st_rb;
    etc_stop_t   sp_rb;
    logic [1:0]  meas_run;
    int          mismatches   = 0;
    int          total_checks = 0;

    always #25 ref_clk = ~ref_clk;

    etc_trigger_top #(.CYC_PER_MS(CPM)) etc_trigger_top_inst (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .EXT_TRIG_PIN(ext_pin),
        .ENABLE_WR(en_wr), .ENABLE_IN(en_in), .POLARITY_WR(pol_wr),
        .POLARITY_IN(pol_in), .DELAY_WR(dly_wr), .DELAY_IN(dly_in),
        .START_WR(st_wr), .START_IN(st_in), .STOP_WR(sp_wr), .STOP_IN(sp_in),
        .ARM_WR(arm_wr), .ARM_IN(arm_in), .SOFT_KEY(soft_key),
        .EXT_TRIGGER_CHANNEL_ENABLE(chan_en), .EXT_ENABLE(ext_en),
        .TRIGGER_POLARITY_SELECT(pol_rb), .TRIGGER_DELAY_MS(dly_rb),
        .START_EVENT_SELECT(st_rb), .STOP_EVENT_SELECT(sp_rb),
        .ARM_STATE(arm_st), .MEAS_RUN(meas_run), .TRIG_EVENT(trig_ev));

    etc_trig_source #(.HOLD(4)) etc_trig_source_inst (.clk(ref_clk), .pin(ext_pin));

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // sel: 0 enable, 1 polarity, 2 holdoff, 3 start, 4 stop, 5 arm
    task automatic wr(input int sel, input logic [9:0] v);
        @(posedge ref_clk);
        en_in  <= v[1:0];
        pol_in <= v[0];
        dly_in <= v;
        st_in  <= v[1:0];
        sp_in  <= v[2:0];
        arm_in <= v[0];
        {arm_wr, sp_wr, st_wr, dly_wr, pol_wr, en_wr} <= 6'h01 << sel;
        @(posedge ref_clk);
        {arm_wr, sp_wr, st_wr, dly_wr, pol_wr, en_wr} <= 6'h00;
        tick(1);
    endtask : wr

    // pin change then a bounded watch for the one-cycle event pulse
    task automatic pin_evt(input logic lvl, input logic exp);
        int n;
        n = 0;
        etc_trig_source_inst.drive(lvl);
        while (trig_ev !== 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
        chk("trig_event", exp, trig_ev);
        if (exp && n == 12) give_verdict();
    endtask : pin_evt

    task automatic test_end(input string name);
        $display("%s finished, %0d mismatches so far", name, mismatches);
    endtask : test_end

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        chk("rst_enable", 10'h000, ext_en);
        chk("rst_polarity", 10'h001, pol_rb);
        chk("rst_delay", 10'h000, dly_rb);
        chk("rst_start", 10'h000, st_rb);
        tick(2);
        chk("cont_run", 10'h003, meas_run);
        chk("cont_arm", 10'h001, arm_st);
        test_end("reset");
        for (int k = 0; k < 4; k++) begin
            wr(0, k);
            chk("enable_rb", k, ext_en);
            chk("chan_enable", k != 0, chan_en);
            wr(3, k);
            chk("start_rb", k, st_rb);
        end
        for (int k = 0; k < 2; k++) begin
            wr(1, k);
            chk("polarity_rb", k, pol_rb);
        end
        wr(2, 1000);
        chk("delay_max", 10'h3e8, dly_rb);
        wr(2, 1001);
        chk("delay_refused", 10'h3e8, dly_rb);
        test_end("settings");
        // holdoff 2 ms, channel A, rising edge
        wr(2, 2);
        wr(3, 1);
        wr(0, 0);
        wr(5, 0);
        chk("armed_state", 10'h000, arm_st);
        pin_evt(1'b1, 1'b0);
        wr(0, 1);
        pin_evt(1'b0, 1'b0);
        chk("still_armed", 10'h000, arm_st);
        pin_evt(1'b1, 1'b1);
        // run starts two edges after the last millisecond step
        tick(2 * CPM + 1);
        chk("in_holdoff", 10'h000, meas_run);
        tick(1);
        chk("run_a_only", 10'h001, meas_run);
        chk("triggered", 10'h001, arm_st);
        test_end("external start");
        // falling edge, channel B, no holdoff, then stop on trigger
        wr(1, 0);
        wr(0, 2);
        wr(2, 0);
        wr(5, 0);
        pin_evt(1'b0, 1'b1);
        tick(1);
        chk("zero_hold_gap", 10'h000, meas_run);
        tick(1);
        chk("run_b_only", 10'h002, meas_run);
        wr(4, 1);
        pin_evt(1'b1, 1'b0);
        chk("still_run", 10'h002, meas_run);
        pin_evt(1'b0, 1'b1);
        tick(2);
        chk("stopped", 10'h000, meas_run);
        chk("done_state", 10'h001, arm_st);
        test_end("stop on trigger");
        // soft key start, stop code 7 refused on the way
        wr(4, 0);
        wr(4, 7);
        chk("stop_refused", 10'h000, sp_rb);
        wr(3, 2);
        wr(5, 0);
        tick(3);
        chk("key_waiting", 10'h000, arm_st);
        @(posedge ref_clk);
        soft_key <= 1'b1;
        @(posedge ref_clk);
        soft_key <= 1'b0;
        tick(1);
        chk("key_run", 10'h003, meas_run);
        test_end("soft key start");
        wr(3, 3);
        wr(5, 0);
        tick(3);
        chk("cmd_waiting", 10'h000, meas_run);
        wr(5, 1);
        chk("cmd_run", 10'h003, meas_run);
        chk("cmd_state", 10'h001, arm_st);
        test_end("arm command start");
        // stop on arm command 0, then on the soft key
        wr(4, 3);
        wr(5, 0);
        chk("arm_stop", 10'h000, meas_run);
        chk("arm_stop_state", 10'h001, arm_st);
        wr(5, 0);
        chk("rearmed", 10'h000, arm_st);
        wr(4, 2);
        wr(5, 1);
        chk("cmd_run_again", 10'h003, meas_run);
        @(posedge ref_clk);
        soft_key <= 1'b1;
        @(posedge ref_clk);
        soft_key <= 1'b0;
        tick(1);
        chk("key_stop", 10'h000, meas_run);
        chk("key_stop_state", 10'h001, arm_st);
        test_end("stop on command and key");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
